/* File: flash_write_guard_secure_region.sv */
// Flash write guard and secured region command interface behind an APB port
`timescale 1ns/10ps
`include "flash_guard_cfg.svh"

// Summary of operation
// [RQ1] Low program voltage blocks all programming
// [RQ2] Supply lockout rejects writes, returns to read; CONFIG register writes are still accepted during lockout
// [RQ3] Power-up strap blocks first write command
// [RQ4] Deselected and not reset: outputs off
// [RQ5] Deselect never aborts running program
// [RQ6] Async sleep after stable address time
// [RQ7] Long reset pulse aborts, clears, ignores access
// [RQ8] Host reissues operation cut by reset
// [RQ9] Output enable high turns outputs off
// [RQ10] Secured region is 256 words, two halves
// [RQ11] Ident offset 03h reports both lock flags
// [RQ12] Factory flag one; customer flag sticky
// [RQ13] Other banks usable in secured mode
// [RQ14] Reset returns to normal array map
// [RQ15] Burst in secured region wraps FFh-00h
// [RQ16] Only sector zero maps to secured array
// [RQ17] No secured access during embedded operation; OFF_BURST register reads still return secured words while busy
// [RQ18] Customer area programs once, locks forever
// [RQ19] No bypass; banks 1-15 readable meanwhile
// [RQ20] AA/55/88 sequence enters secured mode
// [RQ21] AA/55/A0 then data programs customer word
// [RQ22] AA/55/90/00 sequence leaves secured mode
module flash_write_guard_secure_region (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        program_voltage_low,
	input  wire logic        supply_low,
	input  wire logic        chip_en_n,
	input  wire logic        out_en_n,
	input  wire logic        write_en_n,
	input  wire logic        flash_rst_n,
	input  wire logic        array_busy,
	input  wire logic [15:0] array_rdata,
	output logic [19:0]      array_addr,
	output logic [15:0]      dq_o,
	output logic             dq_oe,
	output logic             sleep_active,
	output logic             secured_mode
);
	import flash_guard_pkg::*;

	// State
	cmd_state_t  cmd_state_r;
	cmd_state_t  cmd_nxt;
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic [19:0] array_addr_r;
	logic [15:0] dq_o_r;
	logic        dq_oe_r;
	logic        secured_r;
	logic        burst_mode_r;
	logic        cust_locked_r;
	logic [7:0]  burst_ptr_r;
	logic [7:0]  prog_cnt_r;
	logic [7:0]  pend_off_r;
	logic [15:0] pend_data_r;
	logic [7:0]  stable_cnt_r;
	logic [19:0] last_addr_r;
	logic        sleep_r;
	logic [3:0]  rst_cnt_r;
	logic        rst_hold_r;
	logic        pwrup_chk_r;
	logic        pwrup_block_r;
	logic        enter_sec;
	logic        leave_sec;
	logic        start_prog;

	// Bus decode
	logic [19:0] word_addr;
	logic [11:0] cmd_addr;
	logic [15:0] cmd_data;
	logic [7:0]  reg_off;
	logic        reg_space;
	logic        setup;
	logic        access;
	logic        fetch;
	logic        xfer_done;
	assign word_addr = paddr[21:2];
	assign cmd_addr  = word_addr[11:0];
	assign cmd_data  = pwdata[15:0];
	assign reg_off   = paddr[7:0];
	assign reg_space = paddr[`REG_SPACE_BIT];
	assign setup     = psel && !penable;
	assign access    = psel && penable;
	assign fetch     = access && !pready_r;
	assign xfer_done = access && pready_r;

	// Guard conditions
	logic rd_block;
	logic wr_ok;
	logic reg_wr;
	logic abort;
	logic prog_busy;
	logic busy_any;
	logic standby;
	logic mem_we;
	assign standby   = chip_en_n && flash_rst_n;                                // [RQ4]
	assign rd_block  = !flash_rst_n || chip_en_n;                               // [RQ7]
	assign wr_ok     = xfer_done && pwrite && !reg_space && !rd_block
		&& !supply_low && !pwrup_block_r;                                       // [RQ2] [RQ3]
	assign reg_wr    = xfer_done && pwrite && reg_space;
	assign abort     = rst_hold_r || supply_low;                                // [RQ2] [RQ7]
	assign prog_busy = prog_cnt_r != 8'h00;
	assign busy_any  = prog_busy || array_busy;
	assign mem_we    = prog_cnt_r == 8'h01 && !abort;

	// Address map of the secured region
	logic in_sector0;
	logic in_sec_span;
	logic bank0;
	logic cust_target;
	logic prog_allowed;
	logic at_first;
	assign in_sector0   = word_addr[19:14] == 6'h00;                            // [RQ16]
	assign in_sec_span  = word_addr[13:8] == 6'h00;                             // [RQ10]
	assign bank0        = word_addr[19:16] == 4'h0;
	assign cust_target  = secured_r && in_sector0 && in_sec_span && word_addr[7]; // [RQ10]
	assign prog_allowed = cust_target && !cust_locked_r && !program_voltage_low
		&& !busy_any;                                                           // [RQ1] [RQ18]
	assign at_first     = cmd_addr == `CMD_FIRST_ADDR;

	// Secured storage, one word per entry; erased after power-up
	logic [15:0] sec_rd [`SEC_WORDS];
	generate
		for (genvar i = 0; i < `SEC_WORDS; i++)
		begin : g_word
			logic [15:0] word_r;
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					word_r <= `ERASED_WORD;
				else if (clk_en && mem_we && pend_off_r == 8'(i))
					word_r <= word_r & pend_data_r;     // Flash only clears bits [RQ18]
			end
			assign sec_rd[i] = word_r;
		end
	endgenerate

	// Flash window read selection
	logic [15:0] sec_word;
	logic [15:0] flash_rd;
	assign sec_word = sec_rd[word_addr[7:0]];
	assign flash_rd = rd_block ? 16'h0000 :                                     // [RQ7]
		(secured_r && in_sector0) ?                                             // [RQ16]
			(busy_any ? `BUSY_WORD :                                            // [RQ17]
			(in_sec_span ? sec_word : `UNDEF_WORD)) :                           // [RQ10]
		(prog_busy && bank0) ? `BUSY_WORD : array_rdata;                        // [RQ13] [RQ19]

	// Register read selection
	logic [15:0] burst_word;
	logic [31:0] ident_word;
	logic [31:0] status_word;
	logic [31:0] reg_rd;
	logic        reg_hit;
	logic        burst_start;
	logic        burst_adv;
	assign burst_word  = sec_rd[8'(burst_ptr_r + 8'h01)];                       // [RQ15]
	assign ident_word  = (32'h1 << `FACTORY_LOCK_FLAG_BIT)
		| ({31'h0, cust_locked_r} << `CUSTOMER_LOCK_FLAG_BIT);                  // [RQ11] [RQ12]
	assign status_word = {24'h0, rst_hold_r, pwrup_block_r, cust_locked_r, supply_low,
		standby, sleep_r, busy_any, secured_r};
	assign reg_hit = reg_off == `OFF_CONFIG || reg_off == `OFF_STATUS
		|| reg_off == `OFF_LOCK || reg_off == `OFF_IDENT || reg_off == `OFF_BURST;
	assign reg_rd  = (reg_off == `OFF_CONFIG) ? {31'h0, burst_mode_r} :
		(reg_off == `OFF_STATUS) ? status_word :
		(reg_off == `OFF_LOCK) ? {31'h0, cust_locked_r} :
		(reg_off == `OFF_IDENT) ? ident_word :
		(reg_off == `OFF_BURST && burst_mode_r && secured_r) ? {16'h0, burst_word} :
		32'h0000_0000;
	assign burst_start = fetch && !pwrite && !reg_space && !rd_block && burst_mode_r
		&& secured_r && in_sector0 && in_sec_span;
	assign burst_adv   = fetch && !pwrite && reg_space && reg_off == `OFF_BURST
		&& burst_mode_r && secured_r && !busy_any;

	// Command sequencer; unknown cycles fall back to read, no bypass mode
	always_comb
	begin
		cmd_nxt    = cmd_state_r;
		enter_sec  = 1'b0;
		leave_sec  = 1'b0;
		start_prog = 1'b0;
		if (abort)
			cmd_nxt = ST_READ;                                                  // [RQ2] [RQ7]
		else if (wr_ok && !prog_busy)
		begin
			cmd_nxt = ST_READ;
			case (cmd_state_r)
				ST_READ:
					if (at_first && cmd_data == `CMD_UNLOCK1_DATA)
						cmd_nxt = ST_UNL1;
				ST_UNL1:
					if (cmd_addr == `CMD_SECOND_ADDR && cmd_data == `CMD_UNLOCK2_DATA)
						cmd_nxt = ST_UNL2;
				ST_UNL2:
					if (at_first && cmd_data == `CMD_ENTRY_DATA)
						enter_sec = !busy_any;                                  // [RQ17] [RQ20]
					else if (at_first && cmd_data == `CMD_PROGRAM_DATA && secured_r
						&& !program_voltage_low)
						cmd_nxt = ST_PROG;                                      // [RQ1] [RQ21]
					else if (at_first && cmd_data == `CMD_EXIT_DATA && secured_r)
						cmd_nxt = ST_EXIT;                                      // [RQ22]
				ST_PROG:
					start_prog = prog_allowed;                                  // [RQ19] [RQ21]
				ST_EXIT:
					leave_sec = cmd_data == `CMD_EXIT_FINAL_DATA;               // [RQ22]
				default:
					cmd_nxt = ST_READ;
			endcase
		end
	end

	// Address stability and flash reset pulse counting
	logic        addr_changed;
	logic [7:0]  stable_nxt;
	logic [3:0]  rst_cnt_nxt;
	assign addr_changed = psel && word_addr != last_addr_r;
	assign stable_nxt   = addr_changed ? 8'h00 :
		(stable_cnt_r == 8'(`SLEEP_CYCLES)) ? stable_cnt_r : 8'(stable_cnt_r + 8'h01);
	assign rst_cnt_nxt  = flash_rst_n ? 4'h0 :
		(rst_cnt_r == 4'(`RESET_PULSE_CYCLES)) ? rst_cnt_r : 4'(rst_cnt_r + 4'h1);

	// Sequencer and mode flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_state_r <= ST_READ;                                             // [RQ3]
			secured_r   <= 1'b0;                                                // [RQ14]
		end
		else if (clk_en)
		begin
			cmd_state_r <= cmd_nxt;
			if (abort || leave_sec)
				secured_r <= 1'b0;                                              // [RQ14] [RQ22]
			else if (enter_sec)
				secured_r <= 1'b1;                                              // [RQ20]
		end
	end

	// Embedded program; chip select plays no part so deselect never stops it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prog_cnt_r  <= 8'h00;
			pend_off_r  <= 8'h00;
			pend_data_r <= `ERASED_WORD;
		end
		else if (clk_en)
		begin
			if (abort)
				prog_cnt_r <= 8'h00;                                            // [RQ2] [RQ7]
			else if (start_prog)
			begin
				prog_cnt_r  <= 8'(`SEC_PROGRAM_CYCLES);
				pend_off_r  <= word_addr[7:0];
				pend_data_r <= cmd_data;
			end
			else if (prog_busy)
				prog_cnt_r <= 8'(prog_cnt_r - 8'h01);                           // [RQ5]
		end
	end

	// Software registers; the customer lock is a one-way latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			burst_mode_r  <= `CFG_RESET;
			cust_locked_r <= 1'b0;
			burst_ptr_r   <= 8'h00;
		end
		else if (clk_en)
		begin
			if (rst_hold_r)
				burst_mode_r <= `CFG_RESET;                                     // [RQ7]
			else if (reg_wr && reg_off == `OFF_CONFIG)
				burst_mode_r <= pwdata[`CFG_BURST_BIT];
			if (reg_wr && reg_off == `OFF_LOCK && pwdata[0] && !program_voltage_low
				&& !supply_low && !busy_any && secured_r)
				cust_locked_r <= 1'b1;                                          // [RQ1] [RQ18]
			if (burst_start)
				burst_ptr_r <= word_addr[7:0];
			else if (burst_adv)
				burst_ptr_r <= 8'(burst_ptr_r + 8'h01);                         // [RQ15]
		end
	end

	// Reset pulse, power-up strap and sleep tracking
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rst_cnt_r     <= 4'h0;
			rst_hold_r    <= 1'b0;
			pwrup_chk_r   <= 1'b1;
			pwrup_block_r <= 1'b0;
			stable_cnt_r  <= 8'h00;
			last_addr_r   <= 20'h00000;
			sleep_r       <= 1'b0;
		end
		else if (clk_en)
		begin
			rst_cnt_r  <= rst_cnt_nxt;
			rst_hold_r <= !flash_rst_n && rst_cnt_r == 4'(`RESET_PULSE_CYCLES); // [RQ7]
			pwrup_chk_r <= 1'b0;
			if (pwrup_chk_r)
				pwrup_block_r <= !write_en_n && !chip_en_n && !flash_rst_n && out_en_n; // [RQ3]
			else if (write_en_n)
				pwrup_block_r <= 1'b0;
			stable_cnt_r <= stable_nxt;
			if (psel)
				last_addr_r <= word_addr;
			sleep_r <= !burst_mode_r && stable_cnt_r == 8'(`SLEEP_CYCLES);    // [RQ6]
		end
	end

	// APB answer: one wait state so the array has a cycle to respond
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r     <= 1'b0;
			prdata_r     <= 32'h0000_0000;
			pslverr_r    <= 1'b0;
			array_addr_r <= 20'h00000;
		end
		else if (clk_en)
		begin
			pready_r  <= fetch;
			pslverr_r <= fetch && reg_space && !reg_hit;
			if (fetch)
				prdata_r <= reg_space ? reg_rd : {16'h0000, flash_rd};
			if (setup && !reg_space)
				array_addr_r <= word_addr;
		end
	end

	// Data pins; read data stays latched through sleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dq_o_r  <= 16'h0000;
			dq_oe_r <= 1'b0;
		end
		else if (clk_en)
		begin
			dq_oe_r <= !chip_en_n && !out_en_n && flash_rst_n;                  // [RQ4] [RQ9]
			if (fetch && !pwrite && !reg_space && !rd_block)
				dq_o_r <= flash_rd;                                             // [RQ6]
		end
	end

	assign pready       = pready_r;
	assign prdata       = prdata_r;
	assign pslverr      = pslverr_r;
	assign array_addr   = array_addr_r;
	assign dq_o         = dq_o_r;
	assign dq_oe        = dq_oe_r;
	assign sleep_active = sleep_r;
	assign secured_mode = secured_r;

	// Checks
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	vpp_inhibit_a: // [RQ1]
	assert property (program_voltage_low && prog_cnt_r == 8'h00 |=> prog_cnt_r == 8'h00)
		else $error("program started while program voltage low");

	lockout_read_a: // [RQ2]
	assert property (clk_en && supply_low |=> cmd_state_r == ST_READ && prog_cnt_r == 8'h00)
		else $error("lockout did not return to read");

	powerup_block_a: // [RQ3]
	assert property (pwrup_block_r |-> cmd_state_r == ST_READ)
		else $error("command accepted during power-up inhibit");

	output_off_a: // [RQ9]
	assert property (clk_en && (chip_en_n || out_en_n) |=> !dq_oe_r)
		else $error("data pins driven while disabled");

	deselect_runs_a: // [RQ5]
	assert property (clk_en && chip_en_n && prog_cnt_r > 8'h01 && !abort
		|=> prog_cnt_r == 8'($past(prog_cnt_r) - 8'h01))
		else $error("program stalled on deselect");

	sync_no_sleep_a: // [RQ6]
	assert property (clk_en && burst_mode_r |=> !sleep_r)
		else $error("sleep entered in burst mode");

	reset_abort_a: // [RQ7]
	assert property (clk_en && rst_hold_r |=> prog_cnt_r == 8'h00 && !secured_r && !burst_mode_r)
		else $error("hardware reset did not abort");

	ident_flags_a: // [RQ11]
	assert property (clk_en && fetch && reg_space && reg_off == `OFF_IDENT
		|=> prdata_r[7] && prdata_r[6] == $past(cust_locked_r))
		else $error("wrong lock flags on identification read");

	lock_sticky_a: // [RQ18]
	assert property (cust_locked_r |=> cust_locked_r)
		else $error("customer lock cleared");

	entry_denied_a: // [RQ17]
	assert property (clk_en && busy_any && !secured_r |=> !secured_r)
		else $error("secured entry during embedded operation");

	burst_wrap_a: // [RQ15]
	assert property (clk_en && burst_adv && burst_ptr_r == 8'hFF |=> burst_ptr_r == 8'h00)
		else $error("burst pointer did not wrap");

	exit_restores_a: // [RQ22]
	assert property (clk_en && leave_sec |=> !secured_r ##1 !secured_r || enter_sec)
		else $error("secured mode kept after exit");

	entry_seen_c: cover property (clk_en && enter_sec && !abort ##1 secured_r);
	program_seen_c: cover property (start_prog ##[1:80] mem_we);
	exit_seen_c: cover property (secured_r ##[1:20] !secured_r);
	lock_seen_c: cover property (!cust_locked_r ##1 cust_locked_r);
endmodule

/* File: flash_guard_cfg.svh */
// Offsets, field positions, reset values and timing counts of the flash write guard
`ifndef FLASH_GUARD_CFG_SVH
`define FLASH_GUARD_CFG_SVH

// Register space select and register offsets (byte addresses)
`define REG_SPACE_BIT          22
`define OFF_CONFIG             8'h00
`define OFF_STATUS             8'h04
`define OFF_LOCK               8'h08
`define OFF_IDENT              8'h0C
`define OFF_BURST              8'h10

// Field positions and reset values
`define CFG_BURST_BIT          0
`define CFG_RESET              1'b0
`define FACTORY_LOCK_FLAG_BIT  7
`define CUSTOMER_LOCK_FLAG_BIT 6
`define SEC_WORDS              256
`define ERASED_WORD            16'hFFFF
`define UNDEF_WORD             16'hFFFF
`define BUSY_WORD              16'h0040

// Command cycles
`define CMD_FIRST_ADDR         12'h555
`define CMD_SECOND_ADDR        12'h2AA
`define CMD_UNLOCK1_DATA       16'h00AA
`define CMD_UNLOCK2_DATA       16'h0055
`define CMD_ENTRY_DATA         16'h0088
`define CMD_PROGRAM_DATA       16'h00A0
`define CMD_EXIT_DATA          16'h0090
`define CMD_EXIT_FINAL_DATA    16'h0000

// Timing: 200 MHz clock
`define CLK_PERIOD_NS          5
`define ADDR_ACCESS_TIME_NS    70
`define SLEEP_MARGIN_NS        20
`define SLEEP_CYCLES   (((`ADDR_ACCESS_TIME_NS + `SLEEP_MARGIN_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_MIN_NS     30
`define RESET_PULSE_CYCLES     ((`RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEC_PROGRAM_CYCLES     64

`endif

/* File: flash_guard_pkg.sv */
// Types shared by the flash write guard
package flash_guard_pkg;
	typedef enum logic [2:0] {ST_READ, ST_UNL1, ST_UNL2, ST_PROG, ST_EXIT} cmd_state_t;
endpackage

/* File: array_model.sv */
// Main array model on the far side of the guard
`timescale 1ns/10ps
module array_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [19:0] array_addr,
	output logic      [15:0] array_rdata
);
	// Data settles within the cycle after the address moves; the guard samples it one edge later
	assign array_rdata = presetn ? (array_addr[15:0] ^ {array_addr[19:16], 12'hC3A}) : 16'h0000;
endmodule

/* File: test_flash_write_guard_secure_region.sv */
// Self-checking bench for the flash write guard and secured region
`timescale 1ns/10ps
`include "flash_guard_cfg.svh"
module test_flash_write_guard_secure_region;
	localparam logic [31:0] RG = 32'h00000001 << `REG_SPACE_BIT;
	logic        pclk                = 1'b0;
	logic        presetn             = 1'b0;
	logic        clk_en              = 1'b1;
	logic        psel                = 1'b0;
	logic        penable             = 1'b0;
	logic        pwrite              = 1'b0;
	logic [31:0] paddr               = 32'h00000000;
	logic [31:0] pwdata              = 32'h00000000;
	logic        program_voltage_low = 1'b0;
	logic        supply_low          = 1'b0;
	logic        chip_en_n           = 1'b0;
	logic        out_en_n            = 1'b1;
	logic        write_en_n          = 1'b0;
	logic        flash_rst_n         = 1'b0;
	logic        array_busy          = 1'b0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [15:0] array_rdata;
	logic [19:0] array_addr;
	logic [15:0] dq_o;
	logic        dq_oe;
	logic        sleep_active;
	logic        secured_mode;
	int          n_errors            = 0;
	int          samples_checked     = 0;
	int          seed;
	logic [31:0] rd;
	logic        er;
	logic [15:0] d1;
	logic [15:0] d2;
	logic [19:0] w;

	flash_write_guard_secure_region dut (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.program_voltage_low(program_voltage_low), .supply_low(supply_low),
		.chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
		.flash_rst_n(flash_rst_n), .array_busy(array_busy), .array_rdata(array_rdata),
		.array_addr(array_addr), .dq_o(dq_o), .dq_oe(dq_oe),
		.sleep_active(sleep_active), .secured_mode(secured_mode)
	);
	array_model array_far (
		.pclk(pclk), .presetn(presetn), .array_addr(array_addr), .array_rdata(array_rdata)
	);

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// Expected main array contents, written apart from the model
	function automatic logic [15:0] arr(input logic [19:0] a);
		return a[15:0] ^ {a[19:16], 12'hC3A};
	endfunction

	function automatic logic [31:0] fa(input logic [19:0] a);
		return {10'h000, a, 2'b00};
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			n_errors++;
			test_done();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic fw(input logic [19:0] a, input logic [15:0] d);
		apb(1'b1, fa(a), {16'h0000, d});
	endtask

	task automatic fr(input logic [19:0] a);
		apb(1'b0, fa(a), 32'h00000000);
	endtask

	task automatic seq3(input logic [15:0] third);
		fw({8'h00, `CMD_FIRST_ADDR}, `CMD_UNLOCK1_DATA);
		fw({8'h00, `CMD_SECOND_ADDR}, `CMD_UNLOCK2_DATA);
		fw({8'h00, `CMD_FIRST_ADDR}, third);
	endtask

	task automatic prog(input logic [19:0] a, input logic [15:0] d);
		seq3(`CMD_PROGRAM_DATA);
		fw(a, d);
	endtask

	// Bounded wait for the busy flag to drop
	task automatic wait_idle();
		int i;
		for (i = 0; i < 100; i++)
		begin
			apb(1'b0, RG | `OFF_STATUS, 32'h00000000);
			if (rd[1] === 1'b0)
				break;
		end
		if (i == 100)
		begin
			n_errors++;
			test_done();
		end
	endtask

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask

	// Main sequence; reset is applied with the power-up strap on the pins
	initial
	begin
		seed = $urandom(59);
		cyc(2);
		presetn <= 1'b1;
		cyc(1);
		flash_rst_n <= 1'b1;
		apb(1'b0, RG | `OFF_IDENT, 32'h00000000);
		check("ident", rd[7:0], 8'h80);
		apb(1'b0, RG | `OFF_STATUS, 32'h00000000);
		check("pwrup_block", rd[6], 1'b1);
		seq3(`CMD_ENTRY_DATA);
		cyc(2);
		check("strap_entry", secured_mode, 1'b0);
		write_en_n <= 1'b1;
		array_busy <= 1'b1;
		cyc(2);
		seq3(`CMD_ENTRY_DATA);
		cyc(2);
		check("busy_entry", secured_mode, 1'b0);
		array_busy <= 1'b0;
		out_en_n <= 1'b0;
		seq3(`CMD_ENTRY_DATA);
		cyc(2);
		check("entry", secured_mode, 1'b1);
		tend("entry");
		// Region bounds and sector zero remap, random far addresses
		fr(20'h00100);
		check("beyond", rd[15:0], `UNDEF_WORD);
		repeat (4)
		begin
			w = 20'($urandom);
			w[19] = 1'b1;
			fr(w);
			check("outside", rd[15:0], arr(w));
		end
		program_voltage_low <= 1'b1;
		prog(20'h00090, 16'h0000);
		wait_idle();
		program_voltage_low <= 1'b0;
		fr(20'h00090);
		check("vpp_low", rd[15:0], `ERASED_WORD);
		prog(20'h00005, 16'h0000);
		wait_idle();
		fr(20'h00005);
		check("factory", rd[15:0], `ERASED_WORD);
		tend("map");
		// Long pin reset in mid-program, then the host reissues it
		d1 = 16'($urandom);
		apb(1'b1, RG | `OFF_CONFIG, 32'h00000001);
		prog(20'h00086, d1);
		flash_rst_n <= 1'b0;
		fr(20'h00086);
		check("rst_read", rd, 32'h00000000);
		cyc(6);
		check("rst_map", secured_mode, 1'b0);
		check("rst_oe", dq_oe, 1'b0);
		flash_rst_n <= 1'b1;
		cyc(2);
		apb(1'b0, RG | `OFF_CONFIG, 32'h00000000);
		check("rst_cfg", rd[0], 1'b0);
		apb(1'b0, RG | `OFF_STATUS, 32'h00000000);
		check("rst_abort", rd[1], 1'b0);
		seq3(`CMD_ENTRY_DATA);
		prog(20'h00086, d1);
		wait_idle();
		fr(20'h00086);
		check("reissue", rd[15:0], d1);
		tend("pin_reset");
		// Deselect during a program, other banks readable meanwhile
		d2 = 16'($urandom);
		prog(20'h00085, d2);
		chip_en_n <= 1'b1;
		cyc(5);
		apb(1'b0, RG | `OFF_STATUS, 32'h00000000);
		check("deselect_busy", rd[1], 1'b1);
		chip_en_n <= 1'b0;
		fr(20'h00010);
		check("bank0_busy", rd[15:0], `BUSY_WORD);
		fr(20'h10010);
		check("bank1_read", rd[15:0], arr(20'h10010));
		wait_idle();
		fr(20'h00085);
		check("program", rd[15:0], d2);
		tend("program");
		// Burst continuation and wrap, sleep held off in burst mode
		apb(1'b1, RG | `OFF_CONFIG, 32'h00000001);
		fr(20'h00084);
		apb(1'b0, RG | `OFF_BURST, 32'h00000000);
		check("burst_next", rd[15:0], d2);
		fr(20'h000FF);
		apb(1'b0, RG | `OFF_BURST, 32'h00000000);
		check("burst_wrap", rd[15:0], `ERASED_WORD);
		cyc(25);
		check("burst_sleep", sleep_active, 1'b0);
		tend("burst");
		// Lock is permanent; unmapped offset errors
		apb(1'b1, RG | `OFF_LOCK, 32'h00000001);
		apb(1'b0, RG | `OFF_IDENT, 32'h00000000);
		check("ident_locked", rd[7:0], 8'hC0);
		prog(20'h00085, 16'h0000);
		wait_idle();
		fr(20'h00085);
		check("locked_word", rd[15:0], d2);
		apb(1'b0, RG | 32'h00000040, 32'h00000000);
		check("unmapped_err", er, 1'b1);
		check("unmapped_rd", rd, 32'h00000000);
		tend("lock");
		seq3(`CMD_EXIT_DATA);
		fw(20'h0ABCD, `CMD_EXIT_FINAL_DATA);
		cyc(2);
		check("exit", secured_mode, 1'b0);
		fr(20'h00010);
		check("exit_map", rd[15:0], arr(20'h00010));
		tend("exit");
		// Asynchronous sleep keeps the last data
		apb(1'b1, RG | `OFF_CONFIG, 32'h00000000);
		fr(20'h12345);
		cyc(8);
		check("awake", sleep_active, 1'b0);
		cyc(20);
		check("asleep", sleep_active, 1'b1);
		check("sleep_data", dq_o, arr(20'h12345));
		check("sleep_addr", array_addr, 20'h12345);
		tend("sleep");
		// Output enable and standby
		cyc(2);
		check("oe_on", dq_oe, 1'b1);
		out_en_n <= 1'b1;
		cyc(2);
		check("oe_off", dq_oe, 1'b0);
		chip_en_n <= 1'b1;
		out_en_n <= 1'b0;
		cyc(2);
		check("standby_oe", dq_oe, 1'b0);
		apb(1'b0, RG | `OFF_STATUS, 32'h00000000);
		check("standby", rd[3], 1'b1);
		chip_en_n <= 1'b0;
		tend("outputs");
		// Supply lockout leaves secured mode and ignores writes
		seq3(`CMD_ENTRY_DATA);
		cyc(2);
		// Clock enable low must freeze the mode flag even under lockout
		clk_en <= 1'b0;
		supply_low <= 1'b1;
		cyc(3);
		check("frozen", secured_mode, 1'b1);
		clk_en <= 1'b1;
		cyc(3);
		check("lockout_exit", secured_mode, 1'b0);
		seq3(`CMD_ENTRY_DATA);
		cyc(2);
		check("lockout_entry", secured_mode, 1'b0);
		supply_low <= 1'b0;
		tend("lockout");
		test_done();
	end
endmodule
